// *** core/dspt_pkg.sv ***
// dspt_pkg: constants shared by the dual-slope pwm timer.
// assumes a 32-bit ahb-lite register bus and a 16-bit counter.
package dspt_pkg;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] DSPT_OFF_CTRL   = 8'h00; // mode and actions
	localparam logic [7:0] DSPT_OFF_COUNT  = 8'h04; // counter_value, ro
	localparam logic [7:0] DSPT_OFF_CMPA   = 8'h08; // compare_a_value
	localparam logic [7:0] DSPT_OFF_CMPB   = 8'h0C; // compare_b_value
	localparam logic [7:0] DSPT_OFF_CAPTOP = 8'h10; // capture_top_register
	localparam logic [7:0] DSPT_OFF_FLAGS  = 8'h14; // flags, w1c
	localparam logic [7:0] DSPT_OFF_DIR    = 8'h18; // pin_direction_bit

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int DSPT_CTRL_MODE_LSB = 0; // waveform_mode_field [3:0]
	localparam int DSPT_CTRL_ACTA_LSB = 4; // output_action_a_field
	localparam int DSPT_CTRL_ACTB_LSB = 6; // output_action_b_field
	localparam int DSPT_FLAG_OVF      = 0; // overflow_flag
	localparam int DSPT_FLAG_CMPA     = 1; // compare_a_flag
	localparam int DSPT_FLAG_CMPB     = 2; // compare_b_flag
	localparam int DSPT_FLAG_CAP      = 3; // capture_flag
	localparam int DSPT_DIR_A         = 0; // direction bit of pin a
	localparam int DSPT_DIR_B         = 1; // direction bit of pin b

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [3:0]  DSPT_RST_MODE  = 4'h0;
	localparam logic [1:0]  DSPT_RST_ACT   = 2'h0;
	localparam logic [15:0] DSPT_RST_CMP   = 16'h0000;
	localparam logic [15:0] DSPT_RST_CAPTOP = 16'h0000;
	localparam logic [3:0]  DSPT_RST_FLAGS = 4'h0;
	localparam logic [1:0]  DSPT_RST_DIR   = 2'h0;

	// ----------------------------------------------------------------
	// waveform modes, output actions and fixed tops
	// ----------------------------------------------------------------
	localparam logic [3:0] DSPT_MODE_PC8    = 4'h1;
	localparam logic [3:0] DSPT_MODE_PC9    = 4'h2;
	localparam logic [3:0] DSPT_MODE_PC10   = 4'h3;
	localparam logic [3:0] DSPT_MODE_PFC_CT = 4'h8;
	localparam logic [3:0] DSPT_MODE_PFC_CA = 4'h9;
	localparam logic [3:0] DSPT_MODE_PC_CT  = 4'hA;
	localparam logic [3:0] DSPT_MODE_PC_CA  = 4'hB;
	localparam logic [1:0] DSPT_ACT_OFF     = 2'h0;
	localparam logic [1:0] DSPT_ACT_TOGGLE  = 2'h1;
	localparam logic [1:0] DSPT_ACT_NONINV  = 2'h2;
	localparam logic [1:0] DSPT_ACT_INV     = 2'h3;
	localparam logic [15:0] DSPT_TOP8       = 16'h00FF;
	localparam logic [15:0] DSPT_TOP9       = 16'h01FF;
	localparam logic [15:0] DSPT_TOP10      = 16'h03FF;
	localparam logic [15:0] DSPT_BOTTOM     = 16'h0000;

	// counting direction
	typedef enum logic {DSPT_UP, DSPT_DOWN} dspt_dir_t;

endpackage : dspt_pkg

// *** core/dspt_timer.sv ***
// dspt_timer: dual-slope pwm timer (phase correct and phase-and-
// frequency correct) with two compare channels, behind ahb-lite.
// assumes timer_tick is a one-cycle prescaler enable on hclk and that
// port_level carries the normal port data of the two compare pins.
//
// Register access over AHB-Lite and the placing of the registers were left to the implementer.
module dspt_timer #(
	parameter int CNT_W = 16                   // counter width
) (
	input  wire logic              hclk,       // bus and timer clock
	input  wire logic              hresetn,    // async reset, active low
	input  wire logic              hsel,       // slave select
	input  wire logic [31:0]       haddr,      // byte address
	input  wire logic [1:0]        htrans,     // transfer type
	input  wire logic              hwrite,     // write when high
	input  wire logic [2:0]        hsize,      // transfer size
	input  wire logic [31:0]       hwdata,     // write data
	input  wire logic              hready,     // bus ready in
	output logic      [31:0]       hrdata,     // read data
	output logic                   hreadyout,  // slave ready
	output logic                   hresp,      // always okay
	input  wire logic              timer_tick, // prescaled tick enable
	input  wire logic [1:0]        port_level, // normal port data a,b
	output logic                   pin_a_out,  // pin a level
	output logic                   pin_a_oe,   // pin a driven
	output logic                   pin_b_out,  // pin b level
	output logic                   pin_b_oe    // pin b driven
);

	// ----------------------------------------------------------------
	// elaboration check
	// ----------------------------------------------------------------
	if (CNT_W != 16) begin : g_bad_width
		$error("dspt_timer: CNT_W must be 16");
	end

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [15:0]        cnt;       // counter_value
		dspt_pkg::dspt_dir_t dir;      // counting direction
		logic [15:0]        cmpa_act;  // active compare a
		logic [15:0]        cmpb_act;  // active compare b
		logic [15:0]        cmpa_buf;  // buffered compare a
		logic [15:0]        cmpb_buf;  // buffered compare b
		logic [15:0]        captop;    // capture_top_register
		logic [3:0]         mode;      // waveform_mode_field
		logic [1:0]         act_a;     // output_action_a_field
		logic [1:0]         act_b;     // output_action_b_field
		logic [3:0]         flags;     // sticky event flags
		logic [1:0]         pdir;      // pin direction bits
		logic               lvl_a;     // compare_output_a
		logic               lvl_b;     // compare_output_b
		logic               pa_out;
		logic               pa_oe;
		logic               pb_out;
		logic               pb_oe;
		logic               wr_pend;   // write data phase pending
		logic [7:0]         wr_addr;   // latched write offset
		logic [31:0]        rdata;
		logic               rdy;
		logic               resp;
	} dspt_state_t;

	dspt_state_t s_reg;
	dspt_state_t s_next;

	// ----------------------------------------------------------------
	// mode decode and top selection
	// ----------------------------------------------------------------
	logic        is_pc;       // phase correct mode
	logic        is_pfc;      // phase-and-frequency correct mode
	logic        dual;
	logic        fixed_top;
	logic        top_is_a;    // top from compare a
	logic        top_is_cap;  // top from capture-top
	logic [15:0] top;
	logic        at_top;
	logic        at_bot;
	logic        up_phase;
	logic        match_a;
	logic        match_b;
	logic        upd_point;   // compare buffer update tick
	logic        addr_ok;     // address phase taken
	logic [31:0] rd_mux;
	logic [15:0] wmask;

	// mode and top decoding
	always_comb begin
		is_pc      = 1'b0;
		is_pfc     = 1'b0;
		fixed_top  = 1'b0;
		top_is_a   = 1'b0;
		top_is_cap = 1'b0;
		top        = dspt_pkg::DSPT_TOP8;
		case (s_reg.mode)
			dspt_pkg::DSPT_MODE_PC8: begin
				is_pc     = 1'b1;
				fixed_top = 1'b1;
				top       = dspt_pkg::DSPT_TOP8;
			end
			dspt_pkg::DSPT_MODE_PC9: begin
				is_pc     = 1'b1;
				fixed_top = 1'b1;
				top       = dspt_pkg::DSPT_TOP9;
			end
			dspt_pkg::DSPT_MODE_PC10: begin
				is_pc     = 1'b1;
				fixed_top = 1'b1;
				top       = dspt_pkg::DSPT_TOP10;
			end
			dspt_pkg::DSPT_MODE_PC_CT: begin
				is_pc      = 1'b1;
				top_is_cap = 1'b1;
				top        = s_reg.captop;
			end
			dspt_pkg::DSPT_MODE_PC_CA: begin
				is_pc    = 1'b1;
				top_is_a = 1'b1;
				top      = s_reg.cmpa_act;
			end
			dspt_pkg::DSPT_MODE_PFC_CT: begin
				is_pfc     = 1'b1;
				top_is_cap = 1'b1;
				top        = s_reg.captop;
			end
			dspt_pkg::DSPT_MODE_PFC_CA: begin
				is_pfc   = 1'b1;
				top_is_a = 1'b1;
				top      = s_reg.cmpa_act;
			end
			default: begin
				top = dspt_pkg::DSPT_TOP8;
			end
		endcase
	end

	assign dual    = is_pc | is_pfc;
	assign at_top  = (s_reg.cnt == top);
	assign at_bot  = (s_reg.cnt == dspt_pkg::DSPT_BOTTOM);
	// a match at zero counts as rising and at top as falling, so that
	// compare zero stays low and compare top stays high in non-inverting mode
	assign up_phase = at_bot | ((s_reg.dir == dspt_pkg::DSPT_UP) & ~at_top);
	assign match_a  = (s_reg.cnt == s_reg.cmpa_act);
	assign match_b  = (s_reg.cnt == s_reg.cmpb_act);
	assign upd_point = (is_pc & at_top) | (is_pfc & at_bot);
	assign wmask = fixed_top ? top : 16'hFFFF;

	// read multiplexer, evaluated in the address phase
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (haddr[7:0])
			dspt_pkg::DSPT_OFF_CTRL: begin
				rd_mux[3:0] = s_reg.mode;
				rd_mux[5:4] = s_reg.act_a;
				rd_mux[7:6] = s_reg.act_b;
			end
			dspt_pkg::DSPT_OFF_COUNT:  rd_mux[15:0] = s_reg.cnt;
			dspt_pkg::DSPT_OFF_CMPA:   rd_mux[15:0] = s_reg.cmpa_buf;
			dspt_pkg::DSPT_OFF_CMPB:   rd_mux[15:0] = s_reg.cmpb_buf;
			dspt_pkg::DSPT_OFF_CAPTOP: rd_mux[15:0] = s_reg.captop;
			dspt_pkg::DSPT_OFF_FLAGS:  rd_mux[3:0] = s_reg.flags;
			dspt_pkg::DSPT_OFF_DIR:    rd_mux[1:0] = s_reg.pdir;
			default:                   rd_mux = 32'h0000_0000;
		endcase
		if (haddr[31:8] != 24'h00_0000) begin
			rd_mux = 32'h0000_0000;
		end
	end

	assign addr_ok = hsel & htrans[1] & hready;

	// ----------------------------------------------------------------
	// next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		logic [3:0] set_f;
		logic [3:0] clr_f;
		logic       a_drive;
		logic       b_drive;
		set_f   = 4'h0;
		clr_f   = 4'h0;
		a_drive = 1'b0;
		b_drive = 1'b0;
		s_next  = s_reg;

		// bus: zero wait states, read data registered at address phase
		s_next.rdy     = 1'b1;
		s_next.resp    = 1'b0;
		s_next.wr_pend = addr_ok & hwrite;
		if (addr_ok) begin
			s_next.wr_addr = haddr[7:0];
			if (haddr[31:8] != 24'h00_0000) begin
				s_next.wr_addr = 8'hFF;
			end
		end
		if (addr_ok & ~hwrite) begin
			s_next.rdata = rd_mux;
		end

		// register writes in the data phase
		if (s_reg.wr_pend) begin
			case (s_reg.wr_addr)
				dspt_pkg::DSPT_OFF_CTRL: begin
					s_next.mode  = hwdata[dspt_pkg::DSPT_CTRL_MODE_LSB +: 4];
					s_next.act_a = hwdata[dspt_pkg::DSPT_CTRL_ACTA_LSB +: 2];
					s_next.act_b = hwdata[dspt_pkg::DSPT_CTRL_ACTB_LSB +: 2];
				end
				dspt_pkg::DSPT_OFF_CMPA: begin
					s_next.cmpa_buf = hwdata[15:0] & wmask;
				end
				dspt_pkg::DSPT_OFF_CMPB: begin
					s_next.cmpb_buf = hwdata[15:0] & wmask;
				end
				dspt_pkg::DSPT_OFF_CAPTOP: begin
					s_next.captop = hwdata[15:0];
				end
				dspt_pkg::DSPT_OFF_FLAGS: begin
					clr_f = hwdata[3:0];
				end
				dspt_pkg::DSPT_OFF_DIR: begin
					s_next.pdir = hwdata[1:0];
				end
				default: begin
					clr_f = 4'h0;
				end
			endcase
		end

		// outside the dual-slope modes the buffers pass straight through
		if (!dual) begin
			s_next.cmpa_act = s_next.cmpa_buf;
			s_next.cmpb_act = s_next.cmpb_buf;
		end

		// counter, flags, buffer loads and waveform, only on a tick
		if (dual && timer_tick) begin
			if (s_reg.dir == dspt_pkg::DSPT_UP) begin
				if (at_top) begin
					s_next.dir = dspt_pkg::DSPT_DOWN;
					s_next.cnt = s_reg.cnt - 16'h0001;
				end else begin
					s_next.cnt = s_reg.cnt + 16'h0001;
				end
			end else begin
				if (at_bot) begin
					s_next.dir = dspt_pkg::DSPT_UP;
					s_next.cnt = s_reg.cnt + 16'h0001;
				end else begin
					s_next.cnt = s_reg.cnt - 16'h0001;
				end
			end
			if (at_bot) begin
				set_f[dspt_pkg::DSPT_FLAG_OVF] = 1'b1;
			end
			if (match_a) begin
				set_f[dspt_pkg::DSPT_FLAG_CMPA] = 1'b1;
			end
			if (match_b) begin
				set_f[dspt_pkg::DSPT_FLAG_CMPB] = 1'b1;
			end
			if (at_top && top_is_a) begin
				set_f[dspt_pkg::DSPT_FLAG_CMPA] = 1'b1;
			end
			if (at_top && top_is_cap) begin
				set_f[dspt_pkg::DSPT_FLAG_CAP] = 1'b1;
			end
			if (upd_point) begin
				s_next.cmpa_act = s_next.cmpa_buf;
				s_next.cmpb_act = s_next.cmpb_buf;
			end
			// channel a waveform
			if (match_a) begin
				case (s_reg.act_a)
					dspt_pkg::DSPT_ACT_TOGGLE: begin
						if (top_is_a) begin
							s_next.lvl_a = ~s_reg.lvl_a;
						end
					end
					dspt_pkg::DSPT_ACT_NONINV: begin
						s_next.lvl_a = ~up_phase;
					end
					dspt_pkg::DSPT_ACT_INV: begin
						s_next.lvl_a = up_phase;
					end
					default: begin
						s_next.lvl_a = s_reg.lvl_a;
					end
				endcase
			end
			// channel b waveform, no toggle option
			if (match_b) begin
				case (s_reg.act_b)
					dspt_pkg::DSPT_ACT_NONINV: begin
						s_next.lvl_b = ~up_phase;
					end
					dspt_pkg::DSPT_ACT_INV: begin
						s_next.lvl_b = up_phase;
					end
					default: begin
						s_next.lvl_b = s_reg.lvl_b;
					end
				endcase
			end
		end

		// sticky flags: a set in the same cycle beats the clear
		s_next.flags = (s_reg.flags & ~clr_f) | set_f;

		// pin override: toggle on b, or toggle outside modes 9/11 on a,
		// leaves the pin with the normal port
		a_drive = (s_reg.act_a == dspt_pkg::DSPT_ACT_NONINV)
			| (s_reg.act_a == dspt_pkg::DSPT_ACT_INV)
			| ((s_reg.act_a == dspt_pkg::DSPT_ACT_TOGGLE) & top_is_a);
		b_drive = (s_reg.act_b == dspt_pkg::DSPT_ACT_NONINV)
			| (s_reg.act_b == dspt_pkg::DSPT_ACT_INV);
		s_next.pa_out = a_drive ? s_reg.lvl_a : port_level[0];
		s_next.pb_out = b_drive ? s_reg.lvl_b : port_level[1];
		s_next.pa_oe  = s_reg.pdir[dspt_pkg::DSPT_DIR_A];
		s_next.pb_oe  = s_reg.pdir[dspt_pkg::DSPT_DIR_B];
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_reg.cnt      <= dspt_pkg::DSPT_BOTTOM;
			s_reg.dir      <= dspt_pkg::DSPT_UP;
			s_reg.cmpa_act <= dspt_pkg::DSPT_RST_CMP;
			s_reg.cmpb_act <= dspt_pkg::DSPT_RST_CMP;
			s_reg.cmpa_buf <= dspt_pkg::DSPT_RST_CMP;
			s_reg.cmpb_buf <= dspt_pkg::DSPT_RST_CMP;
			s_reg.captop   <= dspt_pkg::DSPT_RST_CAPTOP;
			s_reg.mode     <= dspt_pkg::DSPT_RST_MODE;
			s_reg.act_a    <= dspt_pkg::DSPT_RST_ACT;
			s_reg.act_b    <= dspt_pkg::DSPT_RST_ACT;
			s_reg.flags    <= dspt_pkg::DSPT_RST_FLAGS;
			s_reg.pdir     <= dspt_pkg::DSPT_RST_DIR;
			s_reg.lvl_a    <= 1'b0;
			s_reg.lvl_b    <= 1'b0;
			s_reg.pa_out   <= 1'b0;
			s_reg.pa_oe    <= 1'b0;
			s_reg.pb_out   <= 1'b0;
			s_reg.pb_oe    <= 1'b0;
			s_reg.wr_pend  <= 1'b0;
			s_reg.wr_addr  <= 8'h00;
			s_reg.rdata    <= 32'h0000_0000;
			s_reg.rdy      <= 1'b1;
			s_reg.resp     <= 1'b0;
		end else begin
			s_reg <= s_next;
		end
	end

	// outputs straight from the state flops
	assign hrdata    = s_reg.rdata;
	assign hreadyout = s_reg.rdy;
	assign hresp     = s_reg.resp;
	assign pin_a_out = s_reg.pa_out;
	assign pin_a_oe  = s_reg.pa_oe;
	assign pin_b_out = s_reg.pb_out;
	assign pin_b_oe  = s_reg.pb_oe;

endmodule : dspt_timer

// *** bench/dspt_load.sv ***
// dspt_load: external load on one compare pin, with a pull-down.
// assumes the pin is released whenever its driver enable is low.
module dspt_load (
	input  wire logic drv, // level driven by the timer
	input  wire logic oe,  // timer drives the pin
	output logic      pad  // level seen by the load
);
	timeunit 1ns;
	timeprecision 1ns;

	// released pin sinks to the pull-down level
	assign pad = oe ? drv : 1'b0;
endmodule : dspt_load

// *** bench/dspt_timer_chk.sv ***
// dspt_timer_chk: port assertions for the dual-slope pwm timer.
// assumes it is bound to dspt_timer and sees only its ports.
module dspt_timer_chk #(
	parameter int CNT_W = 16             // counter width
) (
	input wire logic        hclk,        // clock
	input wire logic        hresetn,     // async reset, active low
	input wire logic        hsel,        // slave select
	input wire logic [31:0] haddr,       // byte address
	input wire logic [1:0]  htrans,      // transfer type
	input wire logic        hwrite,      // write when high
	input wire logic [2:0]  hsize,       // transfer size
	input wire logic [31:0] hwdata,      // write data
	input wire logic        hready,      // bus ready in
	input wire logic [31:0] hrdata,      // read data
	input wire logic        hreadyout,   // slave ready
	input wire logic        hresp,       // response
	input wire logic        timer_tick,  // tick enable
	input wire logic [1:0]  port_level,  // normal port data
	input wire logic        pin_a_out,   // pin a level
	input wire logic        pin_a_oe,    // pin a driven
	input wire logic        pin_b_out,   // pin b level
	input wire logic        pin_b_oe     // pin b driven
);
	logic       acc;
	logic       idle;
	logic       wr_ctrl_reg;
	logic [7:0] ctrl_reg;

	// accepted transfer, and a pwm action on pin a without a dual-slope mode
	assign acc  = hsel && htrans[1] && hready;
	assign idle = ctrl_reg[5:4] inside {2'h2, 2'h3} &&
		!(ctrl_reg[3:0] inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB});

	// shadow of the control register, updated with the design's copy
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_ctrl_reg <= 1'b0;
			ctrl_reg    <= 8'h00;
		end else begin
			wr_ctrl_reg <= acc && hwrite &&
				haddr == {24'h0, dspt_pkg::DSPT_OFF_CTRL};
			if (wr_ctrl_reg) ctrl_reg <= hwdata[7:0];
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence rd_flags;
		acc && !hwrite && haddr == {24'h0, dspt_pkg::DSPT_OFF_FLAGS};
	endsequence
	sequence dir_wr;
		acc && hwrite && haddr == {24'h0, dspt_pkg::DSPT_OFF_DIR} ##1 1'b1;
	endsequence

	ready_a: assert property (hreadyout) // zero wait states
		else $error("hreadyout low");
	resp_a: assert property (!hresp) // okay only
		else $error("hresp not okay");
	unmapped_a: assert property (acc && !hwrite && haddr[31:8] != 24'h0
		|=> hrdata == 32'h0) else $error("unmapped read not zero");
	flag_width_a: assert property (rd_flags |=> hrdata[31:4] == 28'h0)
		else $error("flag read upper bits set");
	dir_oe_a: assert property (dir_wr |-> ##2
		{pin_b_oe, pin_a_oe} == $past(hwdata[1:0], 2))
		else $error("driver enable not from direction bits");
	follow_a_a: assert property (ctrl_reg[5:4] == 2'h0
		|=> pin_a_out == $past(port_level[0]))
		else $error("pin a not on port data");
	follow_b_a: assert property (ctrl_reg[7:6] == 2'h0
		|=> pin_b_out == $past(port_level[1]))
		else $error("pin b not on port data");
	idle_hold_a: assert property (idle && $past(idle)
		|=> $stable(pin_a_out)) else $error("pin a moved while idle");
endmodule : dspt_timer_chk

// *** bench/tb_dual_slope_pwm_timer16.sv ***
// tb_dual_slope_pwm_timer16: self-checking bench for dspt_timer.
// assumes a single ahb-lite slave, hready tied to hreadyout.
module tb_dual_slope_pwm_timer16;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [31:0] A_CTL = {24'h0, dspt_pkg::DSPT_OFF_CTRL};
	localparam logic [31:0] A_CNT = {24'h0, dspt_pkg::DSPT_OFF_COUNT};
	localparam logic [31:0] A_CMA = {24'h0, dspt_pkg::DSPT_OFF_CMPA};
	localparam logic [31:0] A_CMB = {24'h0, dspt_pkg::DSPT_OFF_CMPB};
	localparam logic [31:0] A_CAP = {24'h0, dspt_pkg::DSPT_OFF_CAPTOP};
	localparam logic [31:0] A_FLG = {24'h0, dspt_pkg::DSPT_OFF_FLAGS};
	localparam logic [31:0] A_DIR = {24'h0, dspt_pkg::DSPT_OFF_DIR};
	logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0;
	logic        hwrite = 1'b0, timer_tick = 1'b0, rd_dp = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
	logic [31:0] rnd = 32'hD9715603;
	logic [1:0]  htrans = 2'h0, port_level = 2'h0;
	logic [2:0]  hsize = 3'h2;
	logic        hready, hreadyout, hresp, pa, pae, pb, pbe, pad_a, pad_b;
	logic [31:0] exq [$];
	int          err_total = 0, compares = 0;
	// reference model of counter, flags, compare copies and levels
	logic [3:0]  m_mode, m_fl;
	logic [15:0] cnt, cap, aa, ba, ab, bb;
	logic        up, la, lb, ca, ct, pfc;

	always #50 hclk = ~hclk;
	assign hready = hreadyout;

	dspt_timer dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .timer_tick(timer_tick),
		.port_level(port_level), .pin_a_out(pa), .pin_a_oe(pae),
		.pin_b_out(pb), .pin_b_oe(pbe));
	dspt_load load_a (.drv(pa), .oe(pae), .pad(pad_a));
	dspt_load load_b (.drv(pb), .oe(pbe), .pad(pad_b));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	// random normal port data
	always @(posedge hclk) begin
		rnd <= lfsr(rnd);
		port_level <= rnd[1:0];
	end

	task end_of_test;
		if (err_total == 0 && compares > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : end_of_test

	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			$display("unexpected %s exp %h got %h", n, e, g);
			err_total++;
		end
	endtask : chk

	// data-phase watcher: oldest expected read value against hrdata
	always @(posedge hclk) begin
		if (rd_dp && hreadyout) chk("hrdata", exq.pop_front(), hrdata);
		if (hreadyout) rd_dp <= hsel && htrans[1] && !hwrite;
	end

	task wait_rdy;
		int i;
		i = 0;
		do begin
			@(posedge hclk);
			i++;
		end while (hreadyout !== 1'b1 && i < 100);
		if (hreadyout !== 1'b1) begin
			err_total++;
			end_of_test;
		end
	endtask : wait_rdy

	// one single transfer; on reads d is the expected data
	task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= a;
		wait_rdy;
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		if (!w) exq.push_back(d);
		wait_rdy;
	endtask : bus

	task rst;
		hresetn <= 1'b0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		cnt = 16'h0;
		up = 1'b1;
		m_fl = 4'h0;
		la = 1'b0;
		lb = 1'b0;
	endtask : rst

	function automatic logic [15:0] top_of();
		case (m_mode)
			4'h1: return dspt_pkg::DSPT_TOP8;
			4'h2: return dspt_pkg::DSPT_TOP9;
			4'h3: return dspt_pkg::DSPT_TOP10;
			default: return ca ? aa : cap;
		endcase
	endfunction : top_of

	task automatic step;
		logic [15:0] t;
		logic        r;
		t = top_of();
		r = (up && cnt != t) || cnt == 16'h0;
		if (cnt == 16'h0) m_fl[0] = 1'b1;
		if (cnt == aa) m_fl[1] = 1'b1;
		if (cnt == ab) m_fl[2] = 1'b1;
		if (cnt == t && ct) m_fl[3] = 1'b1;
		if (cnt == aa) la = ca ? ~la : ~r;
		if (cnt == ab) lb = r;
		if (pfc ? cnt == 16'h0 : cnt == t) begin
			aa = ba;
			ab = bb;
		end
		if (up && cnt == t) up = 1'b0;
		else if (!up && cnt == 16'h0) up = 1'b1;
		cnt = up ? cnt + 16'h1 : cnt - 16'h1;
	endtask : step

	task tick(input int n);
		repeat (n) begin
			@(posedge hclk);
			timer_tick <= 1'b1;
			step;
		end
		@(posedge hclk);
		timer_tick <= 1'b0;
	endtask : tick

	task cp;
		bus(1'b0, A_CNT, {16'h0, cnt});
		bus(1'b0, A_FLG, {28'h0, m_fl});
		bus(1'b1, A_FLG, 32'hF);
		m_fl = 4'h0;
		chk("pin_a", {31'h0, la}, {31'h0, pa});
		chk("pin_b", {31'h0, lb}, {31'h0, pb});
		chk("pad_a", {31'h0, la}, {31'h0, pad_a});
		chk("pad_b", {31'h0, m_mode[0] & lb}, {31'h0, pad_b});
	endtask : cp

	// reset values, unmapped space, then every dual-slope mode
	initial begin
		logic [3:0]  modes [7];
		logic [15:0] t, v;
		logic [1:0]  act;
		modes = '{4'h1, 4'h2, 4'h3, 4'hA, 4'hB, 4'h8, 4'h9};
		rst;
		for (int i = 0; i < 7; i++) bus(1'b0, 32'(i * 4), 32'h0);
		bus(1'b1, 32'h100, 32'hFFFF);
		bus(1'b0, 32'h100, 32'h0);
		foreach (modes[k]) begin
			rst;
			m_mode = modes[k];
			ca = m_mode[3] & m_mode[0];
			ct = m_mode[3] & ~m_mode[0];
			pfc = m_mode[3] & ~m_mode[1];
			act = ca ? dspt_pkg::DSPT_ACT_TOGGLE : dspt_pkg::DSPT_ACT_NONINV;
			v = ca ? 16'h5 : 16'h2;
			cap = 16'h5;
			aa = v;
			ba = v;
			ab = 16'h0;
			bb = 16'h0;
			bus(1'b1, A_CAP, 32'h5);
			bus(1'b1, A_CMA, {16'h0, v});
			bus(1'b1, A_CTL, {24'h0, dspt_pkg::DSPT_ACT_INV, act, 4'h0});
			// a tick outside the dual-slope modes must leave the counter
			@(posedge hclk) timer_tick <= 1'b1;
			@(posedge hclk) timer_tick <= 1'b0;
			bus(1'b0, A_CNT, 32'h0);
			bus(1'b1, A_CTL, {24'h0, dspt_pkg::DSPT_ACT_INV, act, m_mode});
			bus(1'b1, A_DIR, {30'h0, m_mode[0], 1'b1});
			bus(1'b1, A_CMA, m_mode[3] ? {16'h0, v} : 32'hFC02);
			bus(1'b0, A_CMA, {16'h0, v});
			t = top_of();
			tick(1);
			bus(1'b1, A_CMB, 32'h2);
			bb = 16'h2;
			tick(int'(t) - 1);
			cp;
			tick(1);
			cp;
			tick(int'(t));
			cp;
		end
		end_of_test;
	end
endmodule : tb_dual_slope_pwm_timer16

bind dspt_timer dspt_timer_chk #(.CNT_W(CNT_W)) u_chk (.hclk(hclk),
	.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
	.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.timer_tick(timer_tick), .port_level(port_level),
	.pin_a_out(pin_a_out), .pin_a_oe(pin_a_oe), .pin_b_out(pin_b_out),
	.pin_b_oe(pin_b_oe));
